// >>> rtl/ttc_pkg.sv
// Shared constants and carrier types for the timer trigger control block.
// Assumes one clock that stands for the carrier, so one cycle is one fc period.
package ttc_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] TTC_ADDR_NRT_HI = 8'h10;
  localparam logic [7:0] TTC_ADDR_NRT_LO = 8'h11;
  localparam logic [7:0] TTC_ADDR_CTRL = 8'h12;
  localparam logic [7:0] TTC_ADDR_GPT_HI = 8'h13;
  localparam logic [7:0] TTC_ADDR_GPT_LO = 8'h14;
  localparam logic [7:0] TTC_ADDR_IRQ_STATUS = 8'h20;
  localparam logic [7:0] TTC_ADDR_IRQ_MASK = 8'h21;
  localparam logic [7:0] TTC_ADDR_STATE = 8'h22;

  // Values after reset
  localparam logic [7:0] TTC_RST_CTRL = 8'h00;
  localparam logic [7:0] TTC_RST_TIMEOUT = 8'h00;
  localparam logic [7:0] TTC_RST_IRQ = 8'h00;

  // Trigger select codes; 3'h4 to 3'h7 are reserved and add nothing
  localparam logic [2:0] TTC_TRIG_NONE = 3'h0;
  localparam logic [2:0] TTC_TRIG_RX_END = 3'h1;
  localparam logic [2:0] TTC_TRIG_RX_START = 3'h2;
  localparam logic [2:0] TTC_TRIG_TX_END = 3'h3;

  // Step sizes in carrier periods
  localparam logic [12:0] TTC_GPT_STEP = 13'h0008;
  localparam logic [12:0] TTC_MRT_STEP_FINE = 13'h0040;
  localparam logic [12:0] TTC_MRT_STEP_COARSE = 13'h0200;
  localparam logic [12:0] TTC_NRT_STEP_FINE = 13'h0040;
  localparam logic [12:0] TTC_NRT_STEP_COARSE = 13'h1000;

  // Interrupt status bit positions
  localparam int TTC_IRQ_GPT = 0;
  localparam int TTC_IRQ_NRT = 1;

  // Control register layout, bit 7 first
  typedef struct packed {
    logic [2:0] trig_sel;
    logic rsvd;
    logic mrt_coarse;
    logic nrt_peer_start;
    logic nrt_compliance;
    logic nrt_coarse;
  } ttc_ctrl_t;

  // Protocol events, each a one-cycle pulse from same-clock logic
  typedef struct packed {
    logic rx_end;
    logic rx_start;
    logic tx_end;
    logic peer_field_on;
  } ttc_events_t;

  // No-response timer sequencing
  typedef enum logic [1:0] {
    NRT_IDLE,
    NRT_ARMED,
    NRT_RUN
  } ttc_nrt_state_t;

endpackage

// >>> rtl/ttc_step_div.sv
// Step divider: one-cycle tick every ratio_i cycles while enabled.
// Assumes restart_i aligns the first tick exactly ratio_i cycles later.
`timescale 1ns/100ps
module ttc_step_div
  import ttc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic restart_i,
  input wire logic enable_i,
  input wire logic [12:0] ratio_i,
  output logic tick_o
);

  logic [12:0] count;

  // Tick on the last cycle of each step
  assign tick_o = enable_i && !restart_i && (count == ratio_i - 13'h0001);

  // Phase counter, cleared by a restart so steps line up with the start event
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count <= 13'h0000;
    end else if (restart_i || !enable_i || tick_o) begin
      count <= 13'h0000;
    end else begin
      count <= count + 13'h0001;
    end
  end

endmodule

// >>> rtl/ttc_down_count.sv
// 16-bit one-shot down counter driven by step ticks.
// Assumes load_i and stop_i are one-cycle pulses; load wins over stop.
`timescale 1ns/100ps
module ttc_down_count
  import ttc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic load_i,
  input wire logic [15:0] value_i,
  input wire logic stop_i,
  input wire logic tick_i,
  output logic running_o,
  output logic expire_o
);

  logic [15:0] count;

  // A zero value never starts; reload restarts a running count
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count <= 16'h0000;
      running_o <= 1'b0;
      expire_o <= 1'b0;
    end else begin
      expire_o <= 1'b0;
      if (load_i) begin
        count <= value_i;
        running_o <= (value_i != 16'h0000);
      end else if (stop_i) begin
        running_o <= 1'b0;
      end else if (running_o && tick_i) begin
        count <= count - 16'h0001;
        if (count == 16'h0001) begin
          running_o <= 1'b0;
          expire_o <= 1'b1;
        end
      end
    end
  end

endmodule

// >>> rtl/ttc_timer_trigger.sv
// Timer trigger control: register file, general purpose timer, no-response
// timer sequencing, step rates for the mask-receive timer, and interrupts.
// Assumes all event and command inputs are one-cycle pulses on clk_i, and
// that clk_i stands for the carrier so a step of N/fc is N cycles.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps

module ttc_timer_trigger
  import ttc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic cmd_start_gpt_i,
  input wire logic cmd_start_nrt_i,
  input wire ttc_events_t ev_i,
  input wire logic active_peer_mode_i,
  output logic [7:0] rdata_o,
  output logic irq_o,
  output logic field_off_o,
  output logic nrt_timeout_o,
  output logic mrt_tick_o,
  output logic gpt_running_o,
  output logic nrt_running_o,
  output logic nrt_compliance_o
);

  // Extra trigger decode, used only by the general timer start logic
  function automatic logic ttc_trig_hit(input logic [2:0] sel, input ttc_events_t ev);
    logic hit;
    hit = 1'b0;
    case (sel)
      TTC_TRIG_NONE: hit = 1'b0;
      TTC_TRIG_RX_END: hit = ev.rx_end;
      TTC_TRIG_RX_START: hit = ev.rx_start;
      TTC_TRIG_TX_END: hit = ev.tx_end;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Register storage
  ttc_ctrl_t ctrl;
  logic [7:0] gpt_hi;
  logic [7:0] gpt_lo;
  logic [7:0] nrt_hi;
  logic [7:0] nrt_lo;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;

  // Internal wiring
  logic peer_tx_mode;
  logic gpt_start;
  logic gpt_tick;
  logic gpt_run;
  logic gpt_expire;
  logic own_field_off;
  logic nrt_load;
  logic nrt_stop;
  logic nrt_tick;
  logic nrt_run;
  logic nrt_expire;
  logic mrt_tick;
  logic [12:0] nrt_ratio;
  logic [12:0] mrt_ratio;
  logic [7:0] irq_set;
  logic [7:0] irq_clr;
  logic [7:0] next_rdata;
  ttc_nrt_state_t nrt_state;
  ttc_nrt_state_t next_nrt_state;

  // Peer-to-peer mode with end-of-transmit trigger changes field and NRT handling
  assign peer_tx_mode = active_peer_mode_i && (ctrl.trig_sel == TTC_TRIG_TX_END);

  // ---- Register writes ----

  // Control register keeps all eight bits, reserved bit 4 included
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl <= ttc_ctrl_t'(TTC_RST_CTRL);
    end else if (we_i && addr_i == TTC_ADDR_CTRL) begin
      ctrl <= ttc_ctrl_t'(wdata_i);
    end
  end

  // General purpose timeout bytes
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gpt_hi <= TTC_RST_TIMEOUT;
      gpt_lo <= TTC_RST_TIMEOUT;
    end else if (we_i) begin
      if (addr_i == TTC_ADDR_GPT_HI) begin
        gpt_hi <= wdata_i;
      end
      if (addr_i == TTC_ADDR_GPT_LO) begin
        gpt_lo <= wdata_i;
      end
    end
  end

  // No-response timeout bytes
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nrt_hi <= TTC_RST_TIMEOUT;
      nrt_lo <= TTC_RST_TIMEOUT;
    end else if (we_i) begin
      if (addr_i == TTC_ADDR_NRT_HI) begin
        nrt_hi <= wdata_i;
      end
      if (addr_i == TTC_ADDR_NRT_LO) begin
        nrt_lo <= wdata_i;
      end
    end
  end

  // Interrupt mask, a one lets the matching status bit reach irq_o
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_mask <= TTC_RST_IRQ;
    end else if (we_i && addr_i == TTC_ADDR_IRQ_MASK) begin
      irq_mask <= wdata_i;
    end
  end

  // ---- General purpose timer ----

  // Host command starts it unless the timeout is zero; the selected event may start it as well
  assign gpt_start = cmd_start_gpt_i || ttc_trig_hit(ctrl.trig_sel, ev_i);

  // Steps of 8 carrier periods, phase reset on every start
  ttc_step_div u_gpt_div (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .restart_i(gpt_start),
    .enable_i(gpt_run),
    .ratio_i(TTC_GPT_STEP),
    .tick_o(gpt_tick)
  );

  // Reload on each start so a running count restarts from the full value
  ttc_down_count u_gpt_cnt (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .load_i(gpt_start),
    .value_i({gpt_hi, gpt_lo}),
    .stop_i(1'b0),
    .tick_i(gpt_tick),
    .running_o(gpt_run),
    .expire_o(gpt_expire)
  );

  // Expiry in peer transmit mode switches our field off
  assign own_field_off = gpt_expire && peer_tx_mode;

  // ---- No-response timer sequencing ----

  // A detected response ends the wait; a new start still takes priority
  // Limitation: any start of receive counts as a response, even a frame that later fails
  assign nrt_stop = ev_i.rx_start;

  // Start sources depend on mode and the start-condition bit
  always_comb begin
    next_nrt_state = nrt_state;
    nrt_load = 1'b0;
    case (nrt_state)
      NRT_IDLE, NRT_RUN: begin
        if (cmd_start_nrt_i) begin
          nrt_load = 1'b1;
        end else if (ev_i.tx_end && peer_tx_mode) begin
          next_nrt_state = NRT_ARMED;
        end else if (ev_i.tx_end) begin
          nrt_load = 1'b1;
        end else if (nrt_state == NRT_RUN && (nrt_stop || !nrt_run)) begin
          next_nrt_state = NRT_IDLE;
        end
      end
      NRT_ARMED: begin
        if (cmd_start_nrt_i) begin
          nrt_load = 1'b1;
        end else if (ctrl.nrt_peer_start ? ev_i.peer_field_on : own_field_off) begin
          nrt_load = 1'b1;
        end
      end
      default: begin
        next_nrt_state = NRT_IDLE;
      end
    endcase
    if (nrt_load) begin
      next_nrt_state = NRT_RUN;
    end
  end

  // Sequencer state
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nrt_state <= NRT_IDLE;
    end else begin
      nrt_state <= next_nrt_state;
    end
  end

  // Step of 64 or 4096 carrier periods
  assign nrt_ratio = ctrl.nrt_coarse ? TTC_NRT_STEP_COARSE : TTC_NRT_STEP_FINE;

  ttc_step_div u_nrt_div (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .restart_i(nrt_load),
    .enable_i(nrt_run),
    .ratio_i(nrt_ratio),
    .tick_o(nrt_tick)
  );

  // A zero timeout never starts, so it never times out
  ttc_down_count u_nrt_cnt (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .load_i(nrt_load),
    .value_i({nrt_hi, nrt_lo}),
    .stop_i(nrt_stop),
    .tick_i(nrt_tick),
    .running_o(nrt_run),
    .expire_o(nrt_expire)
  );

  // ---- Mask-receive step rate ----

  // Step of 64 or 512 carrier periods, aligned to end of transmit
  // Runs free between transmits; only its phase after end of transmit matters
  assign mrt_ratio = ctrl.mrt_coarse ? TTC_MRT_STEP_COARSE : TTC_MRT_STEP_FINE;

  ttc_step_div u_mrt_div (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .restart_i(ev_i.tx_end),
    .enable_i(1'b1),
    .ratio_i(mrt_ratio),
    .tick_o(mrt_tick)
  );

  // ---- Interrupts ----

  // Hardware events and software clears; a set in the clearing cycle survives
  always_comb begin
    irq_set = 8'h00;
    irq_set[TTC_IRQ_GPT] = gpt_expire;
    irq_set[TTC_IRQ_NRT] = nrt_expire;
    irq_clr = (we_i && addr_i == TTC_ADDR_IRQ_STATUS) ? wdata_i : 8'h00;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_status <= TTC_RST_IRQ;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  // Level output from a flop fed by the next status value, so it moves with the status
  // bit; a mask write still takes one extra cycle to show
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((irq_status & ~irq_clr) | irq_set) & irq_mask);
    end
  end

  // ---- Register reads ----

  // Read data stands only in the cycle after the strobe; unmapped reads zero
  always_comb begin
    next_rdata = 8'h00;
    if (re_i) begin
      case (addr_i)
        TTC_ADDR_CTRL: next_rdata = ctrl;
        TTC_ADDR_GPT_HI: next_rdata = gpt_hi;
        TTC_ADDR_GPT_LO: next_rdata = gpt_lo;
        TTC_ADDR_NRT_HI: next_rdata = nrt_hi;
        TTC_ADDR_NRT_LO: next_rdata = nrt_lo;
        TTC_ADDR_IRQ_STATUS: next_rdata = irq_status;
        TTC_ADDR_IRQ_MASK: next_rdata = irq_mask;
        TTC_ADDR_STATE: next_rdata = {5'h00, nrt_state == NRT_ARMED, nrt_run, gpt_run};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // ---- Registered outputs ----

  // Field-off and timeout pulses land one cycle after the counter expiry
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      field_off_o <= 1'b0;
      nrt_timeout_o <= 1'b0;
      mrt_tick_o <= 1'b0;
    end else begin
      field_off_o <= own_field_off;
      nrt_timeout_o <= nrt_expire;
      mrt_tick_o <= mrt_tick;
    end
  end

  // Status levels; compliance mode is only signalled, the timer ignores it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gpt_running_o <= 1'b0;
      nrt_running_o <= 1'b0;
      nrt_compliance_o <= 1'b0;
    end else begin
      gpt_running_o <= gpt_run;
      nrt_running_o <= nrt_run;
      nrt_compliance_o <= ctrl.nrt_compliance;
    end
  end

endmodule

// >>> bench/ttc_timer_trigger_properties.sv
// Assertion checker for the timer trigger control block.
// Sees only top-level ports; shadows register writes to know the setup.
`timescale 1ns/100ps
module ttc_props
  import ttc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic cmd_start_gpt_i,
  input wire logic cmd_start_nrt_i,
  input wire ttc_events_t ev_i,
  input wire logic active_peer_mode_i,
  input wire logic [7:0] rdata_o,
  input wire logic irq_o,
  input wire logic field_off_o,
  input wire logic nrt_timeout_o,
  input wire logic mrt_tick_o,
  input wire logic gpt_running_o,
  input wire logic nrt_running_o,
  input wire logic nrt_compliance_o
);
  logic [7:0] sh [5];
  logic [2:0] sel;
  logic [15:0] gv;
  logic [15:0] nv;
  logic [7:0] shr;
  logic cause;

  // Shadow of registers 10h to 14h, indexed by the low address bits
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sh <= '{default: 8'h00};
    end else if (we_i && addr_i >= 8'h10 && addr_i <= 8'h14) begin
      sh[addr_i[2:0]] <= wdata_i;
    end
  end

  // Decoded setup; a zero timeout never starts, so it is no cause
  assign sel = sh[2][7:5];
  assign gv = {sh[3], sh[4]};
  assign nv = {sh[0], sh[1]};
  assign shr = sh[addr_i[2:0]];
  assign cause = gv != 16'h0000 && (cmd_start_gpt_i || (ev_i.rx_end && sel == 3'h1)
    || (ev_i.rx_start && sel == 3'h2) || (ev_i.tx_end && sel == 3'h3));

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_read_idle: assert property (!re_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  a_reg_readback: assert property (
    re_i && addr_i inside {[8'h10:8'h14]} |=> rdata_o == $past(shr))
    else $error("register read back differs from last write");
  a_cmd_start: assert property (
    cmd_start_gpt_i && gv != 16'h0000 |-> ##2 gpt_running_o)
    else $error("start command did not run the general timer");
  a_trig_start: assert property (cause |-> ##2 gpt_running_o)
    else $error("selected event did not run the general timer");
  a_no_extra_start: assert property ($rose(gpt_running_o) |-> $past(cause, 2))
    else $error("general timer started without a cause");
  a_field_off: assert property (
    field_off_o == ($fell(gpt_running_o) && active_peer_mode_i && sel == 3'h3))
    else $error("field off request at the wrong moment");
  a_nrt_timeout: assert property (
    cmd_start_nrt_i && nv == 16'h0001 && sh[2] == 8'h00 |-> ##66 nrt_timeout_o)
    else $error("no-response timeout not after one fine step");
  a_irq_masked: assert property (
    we_i && addr_i == 8'h21 && wdata_i == 8'h00 |-> ##2 !irq_o)
    else $error("interrupt high with everything masked");
  a_compliance: assert property (
    we_i && addr_i == 8'h12 |-> ##2 nrt_compliance_o == $past(wdata_i[1], 2))
    else $error("compliance level does not follow control bit 1");

  // Main scenarios reached
  c_field_off: cover property (field_off_o);
  c_nrt_timeout: cover property (nrt_timeout_o);
  c_irq: cover property ($rose(irq_o));
  c_trig: cover property (cause && !cmd_start_gpt_i);
endmodule

bind ttc_timer_trigger ttc_props ttc_props_i (
  .clk_i, .rstn_i, .addr_i, .wdata_i, .we_i, .re_i, .cmd_start_gpt_i, .cmd_start_nrt_i,
  .ev_i, .active_peer_mode_i, .rdata_o, .irq_o, .field_off_o, .nrt_timeout_o,
  .mrt_tick_o, .gpt_running_o, .nrt_running_o, .nrt_compliance_o);

// >>> bench/ttc_timer_trigger_bench.sv
// Self-checking bench for the timer trigger control block.
// Assumes one clock standing for the carrier; the bench drives all ports.
`timescale 1ns/100ps
module ttc_timer_trigger_bench
  import ttc_pkg::*;
;
  localparam logic [7:0] AD [9] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
    8'h20, 8'h21, 8'h22, 8'h30};
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic cmd_start_gpt_i = 1'b0;
  logic cmd_start_nrt_i = 1'b0;
  ttc_events_t ev_i = '0;
  logic active_peer_mode_i = 1'b0;
  logic [7:0] rdata_o;
  logic irq_o, field_off_o, nrt_timeout_o, mrt_tick_o;
  logic gpt_running_o, nrt_running_o, nrt_compliance_o;
  int n_fail = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h0000_0003;

  ttc_timer_trigger ttc_timer_trigger_i (
    .clk_i, .rstn_i, .addr_i, .wdata_i, .we_i, .re_i, .cmd_start_gpt_i,
    .cmd_start_nrt_i, .ev_i, .active_peer_mode_i, .rdata_o, .irq_o, .field_off_o,
    .nrt_timeout_o, .mrt_tick_o, .gpt_running_o, .nrt_running_o, .nrt_compliance_o);

  // 100 ns period, one cycle per carrier period
  always #50 clk_i = ~clk_i;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected general timer start for select s and stimulus k (3 = command)
  function automatic logic starts(input int s, input int k);
    return k == 3 || s == k + 1;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  // One-cycle pulse of events and commands; returns at the taking edge
  task automatic fire(input logic [3:0] e, input logic g, input logic n);
    @(posedge clk_i);
    ev_i <= ttc_events_t'(e);
    cmd_start_gpt_i <= g;
    cmd_start_nrt_i <= n;
    @(posedge clk_i);
    ev_i <= '0;
    cmd_start_gpt_i <= 1'b0;
    cmd_start_nrt_i <= 1'b0;
  endtask

  // Cycles until a pulse; a lost pulse ends the run as a failure
  task automatic count_to(input logic m, output int n);
    n = 0;
    while (n < 6000) begin
      cyc(1);
      n++;
      if ((m ? mrt_tick_o : nrt_timeout_o) === 1'b1) break;
    end
    if (n == 6000) begin
      n_fail++;
      summarize();
    end
  endtask

  initial begin
    logic [7:0] d;
    logic [15:0] v;
    int n;
    logic pm;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    // Reset values, unmapped place included
    foreach (AD[i]) begin
      rd(AD[i], d);
      check("reset value", d, 8'h00);
    end
    // Random readback; first value sets reserved bit 4 and compliance
    for (int i = 0; i < 9; i++) begin
      v = (i == 0) ? 16'h001a : 16'(rnd());
      wr(AD[2 + i % 3], v[7:0]);
      rd(AD[2 + i % 3], d);
      check("readback", d, v[7:0]);
      if (i % 3 == 0) check("compliance", nrt_compliance_o, v[1]);
    end
    wr(8'h30, 8'hff);
    rd(8'h30, d);
    check("unmapped", d, 8'h00);
    // Every select code against every start source, timeout of one step
    wr(8'h13, 8'h00);
    wr(8'h14, 8'h01);
    wr(8'h21, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr(8'h12, {3'(s), 5'h00});
      for (int k = 0; k < 4; k++) begin
        fire(k < 3 ? 4'h8 >> k : 4'h0, k == 3, 1'b0);
        cyc(2);
        check("gpt start", gpt_running_o, starts(s, k));
        cyc(10);
      end
    end
    // End-of-transmit start, exact expiry, field off in peer mode, interrupt
    wr(8'h21, 8'h01);
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 16'h0101 : 16'(rnd() % 4 + 1);
      pm = 1'(rnd());
      @(posedge clk_i);
      active_peer_mode_i <= pm;
      wr(8'h20, 8'hff);
      wr(8'h13, v[15:8]);
      wr(8'h14, v[7:0]);
      wr(8'h12, 8'h60);
      fire(4'h2, 1'b0, 1'b0);
      cyc(8 * v);
      check("gpt hold", {gpt_running_o, field_off_o}, 2'b10);
      cyc(1);
      check("gpt expiry", {gpt_running_o, field_off_o}, {1'b0, pm});
      cyc(1);
      check("gpt irq", irq_o, 1'b1);
      rd(8'h20, d);
      check("status", d, 8'h01);
    end
    wr(8'h20, 8'h01);
    cyc(2);
    check("irq cleared", irq_o, 1'b0);
    // Mask-receive step rate from control bit 3
    @(posedge clk_i);
    active_peer_mode_i <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      wr(8'h12, {4'h0, 1'(i), 3'h0});
      fire(4'h2, 1'b0, 1'b0);
      count_to(1'b1, n);
      check("mrt step", 16'(n), i ? 16'd512 : 16'd64);
    end
    // No-response timer: fine, coarse, then peer field-on start in peer mode
    wr(8'h10, 8'h00);
    wr(8'h11, 8'h01);
    wr(8'h21, 8'h02);
    for (int i = 0; i < 3; i++) begin
      wr(8'h12, i == 0 ? 8'h00 : (i == 1 ? 8'h01 : 8'h64));
      if (i == 2) begin
        @(posedge clk_i);
        active_peer_mode_i <= 1'b1;
        fire(4'h2, 1'b0, 1'b0);
        cyc(20);
        rd(8'h22, d);
        check("nrt armed", d[2], 1'b1);
      end
      fire(i == 2 ? 4'h1 : 4'h0, 1'b0, i < 2);
      count_to(1'b0, n);
      check("nrt timeout", 16'(n), i == 1 ? 16'd4097 : 16'd65);
      cyc(1);
      check("nrt irq", irq_o, 1'b1);
      wr(8'h20, 8'h02);
    end
    // A response stops the no-response timer before it runs out
    fire(4'h0, 1'b0, 1'b1);
    cyc(10);
    check("nrt running", nrt_running_o, 1'b1);
    fire(4'h4, 1'b0, 1'b0);
    cyc(80);
    check("nrt stopped", nrt_running_o, 1'b0);
    rd(8'h20, d);
    check("response stop", d[1], 1'b0);
    summarize();
  end
endmodule
